// file: hdl/ccs_clock_ctl.sv
`timescale 1ns/100ps
`default_nettype none
module ccs_clock_ctl
    import ccs_pkg::*;
#(
    parameter int DIV_LOG2 = CCS_DIV_LOG2
) (
    input  wire logic                      clock,
    input  wire logic                      rst_n,
    input  wire logic [CCS_CODE_W-1:0]     output_group_disable,
    input  wire logic                      half_speed_select,
    output logic      [CCS_NUM_GROUPS-1:0] group_clk_q,
    output logic                           half_speed_active_q
);

    // ---------------------------------------------------------------------------
    // parameter checks
    // ---------------------------------------------------------------------------
    if (DIV_LOG2 < 0 || DIV_LOG2 > CCS_DIV_MAX) begin : g_bad_div
        $error("ccs_clock_ctl: DIV_LOG2 out of range");
    end

    // ---------------------------------------------------------------------------
    // declarations
    // ---------------------------------------------------------------------------
    ccs_vco_t                    vco;          // internal clock levels
    logic [CCS_CODE_W-1:0]       sd_s1_q;      // shutdown sync stage 1
    logic [CCS_CODE_W-1:0]       sd_s2_q;      // shutdown sync stage 2
    logic                        hs_s1_q;      // select sync stage 1
    logic                        hs_s2_q;      // select sync stage 2
    logic                        req_q;        // select taken on slow clock
    logic                        sel_q;        // 1 = outputs from half clock
    logic                        sel_d;        // next source choice
    logic [CCS_NUM_GROUPS-1:0]   en_q;         // banks currently running
    logic [CCS_NUM_GROUPS-1:0]   en_d;         // next bank enables
    logic [CCS_NUM_GROUPS-1:0]   out_d;        // next output levels
    wire  [CCS_NUM_GROUPS-1:0]   want_w;       // banks the code asks to run
    wire                         both_low_w;   // both internal clocks low
    wire                         src_w;        // selected source level
    wire                         src_next_w;   // source level after the switch

    // ---------------------------------------------------------------------------
    // internal clock divider
    // ---------------------------------------------------------------------------
    ccs_vco_div #(
        .DIV_LOG2 (DIV_LOG2)
    ) u_div (
        .clock (clock),
        .rst_n (rst_n),
        .vco   (vco)
    );

    // ---------------------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------------------
    // stage 1 feeds only stage 2; nothing else looks at it
    // shutdown resynchronised
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sd_s1_q <= CCS_SD_NONE;
            sd_s2_q <= CCS_SD_NONE;
            hs_s1_q <= 1'b0;
            hs_s2_q <= 1'b0;
        end else begin
            sd_s1_q <= output_group_disable;
            sd_s2_q <= sd_s1_q;
            hs_s1_q <= half_speed_select;
            hs_s2_q <= hs_s1_q;
        end
    end

    // ---------------------------------------------------------------------------
    // shutdown decode
    // ---------------------------------------------------------------------------
    // code to bank mask
    assign want_w = ccs_run_mask(sd_s2_q);

    // ---------------------------------------------------------------------------
    // half-speed request on the slow clock
    // ---------------------------------------------------------------------------
    // sampling on the slowest clock keeps the request stable over a whole
    // slow period, so the both-low window below sees one steady value
    // slow-clock sampling
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            req_q <= 1'b0;
        end else if (vco.half_rise) begin
            req_q <= hs_s2_q;
        end
    end

    // ---------------------------------------------------------------------------
    // source switch
    // ---------------------------------------------------------------------------
    assign both_low_w = !vco.nom && !vco.half;
    // the switch lands at counter zero, so the low phase in progress simply
    // runs on into the longer low of the half clock
    // pulse stretched at entry
    assign sel_d      = both_low_w ? req_q : sel_q;
    assign src_w      = sel_q ? vco.half : vco.nom;
    assign src_next_w = sel_d ? vco.half : vco.nom;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sel_q <= 1'b0;
        end else begin
            sel_q <= sel_d;
        end
    end

    // ---------------------------------------------------------------------------
    // bank gating
    // ---------------------------------------------------------------------------
    // a bank changes state only while its source is low, so a high pulse is
    // never cut short and a restart begins on the shared next rising edge
    // stop in low phase
    assign en_d  = src_w ? en_q : want_w;
    assign out_d = {CCS_NUM_GROUPS{src_next_w}} & en_d;

    // ---------------------------------------------------------------------------
    // output registers
    // ---------------------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            en_q                <= CCS_EN_RESET;
            group_clk_q         <= '0;
            half_speed_active_q <= 1'b0;
        end else begin
            en_q                <= en_d;
            group_clk_q         <= out_d;
            half_speed_active_q <= sel_d;
        end
    end

    // ---------------------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    logic past_valid_q;   // one edge seen since reset
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            past_valid_q <= 1'b0;
        end else begin
            past_valid_q <= 1'b1;
        end
    end

    mask_decode_a: assert property (
        (sd_s2_q == CCS_SD_BC) |-> (want_w == 3'h1))
        else $error("bank mask wrong for code 2");

    sync_path_a: assert property (
        past_valid_q && (en_q != $past(en_q)) |-> (en_q == $past(want_w)))
        else $error("bank enable moved without synced code");

    stop_low_a: assert property (
        past_valid_q && $fell(en_q[0]) |-> !$past(src_w) ##0 !group_clk_q[0])
        else $error("bank a stopped during high phase");

    restart_phase_a: assert property (
        past_valid_q && en_q[1] && $past(en_q[1]) |-> group_clk_q[1] == $past(src_next_w))
        else $error("bank b out of phase with source");

    held_low_a: assert property (
        !en_q[2] |-> !group_clk_q[2])
        else $error("stopped bank c not low");

    half_source_a: assert property (
        past_valid_q && sel_q && en_q[0] |-> group_clk_q[0] == $past(vco.half))
        else $error("half speed source not on outputs");

    slow_sample_a: assert property (
        past_valid_q && (req_q != $past(req_q)) |-> $past(vco.half_rise))
        else $error("request taken off the slow clock");

    switch_low_a: assert property (
        past_valid_q && $rose(sel_q) |-> $past(both_low_w) ##0 !group_clk_q[0])
        else $error("switch to half speed outside both-low");

    stretch_a: assert property (
        (DIV_LOG2 >= 1) && past_valid_q && $rose(sel_q) |->
            !group_clk_q[0] ##1 !group_clk_q[0] ##1 !group_clk_q[0])
        else $error("pulse cut at half speed entry");

    return_low_a: assert property (
        past_valid_q && $fell(sel_q) |-> $past(both_low_w))
        else $error("return to nominal outside both-low");

    shrink_a: assert property (
        past_valid_q && !sel_q && !$past(sel_q) && en_q[0] |->
            group_clk_q[0] == $past(vco.nom))
        else $error("nominal speed not restored");

    cov_enter_half: cover property ($rose(sel_q));
    cov_leave_half: cover property ($fell(sel_q));
    cov_bank_stop:  cover property ($fell(en_q[2]));
    cov_bank_start: cover property ($rose(en_q[2]) ##[1:40] group_clk_q[2]);

endmodule
`default_nettype wire

// file: hdl/ccs_pkg.sv
// ---------------------------------------------------------------------------
// shared constants and carriers for the output clock control block
// ---------------------------------------------------------------------------
package ccs_pkg;

    // ---------------------------------------------------------------------------
    // output groups and shutdown codes
    // ---------------------------------------------------------------------------
    localparam int          CCS_NUM_GROUPS  = 3;      // output banks a, b, c
    localparam int          CCS_CODE_W      = 2;      // width of shutdown code
    localparam logic [1:0]  CCS_SD_NONE     = 2'h0;   // every bank running
    localparam logic [1:0]  CCS_SD_C        = 2'h1;   // bank c held low
    localparam logic [1:0]  CCS_SD_BC       = 2'h2;   // banks b and c held low
    localparam logic [1:0]  CCS_SD_ALL      = 2'h3;   // every bank held low
    localparam logic [2:0]  CCS_EN_RESET    = 3'h0;   // banks idle until first low phase

    // ---------------------------------------------------------------------------
    // internal vco clock divider
    // ---------------------------------------------------------------------------
    localparam int          CCS_DIV_LOG2    = 1;      // nominal half period = 2**n cycles
    localparam int          CCS_DIV_MAX     = 8;      // largest divider exponent served
    localparam int          CCS_SYNC_STAGES = 2;      // flip-flops on each pin input

    // pair of internal vco-derived clocks as levels, plus the slow clock's rising tick
    typedef struct packed {
        logic nom;        // nominal-speed clock level
        logic half;       // half-speed clock level
        logic half_rise;  // one-cycle pulse as half goes high
    } ccs_vco_t;

    // decode of a shutdown code into per-bank run enables (bit 0 = bank a)
    function automatic logic [2:0] ccs_run_mask(input logic [1:0] code);
        logic [2:0] m;
        m = 3'h7;
        case (code)
            CCS_SD_NONE: m = 3'h7;
            CCS_SD_C:    m = 3'h3;
            CCS_SD_BC:   m = 3'h1;
            CCS_SD_ALL:  m = 3'h0;
            default:     m = 3'h7;
        endcase
        return m;
    endfunction

endpackage

// file: hdl/ccs_vco_div.sv
`timescale 1ns/100ps
`default_nettype none
// ---------------------------------------------------------------------------
// divider making the nominal and half-speed internal clocks
// ---------------------------------------------------------------------------
module ccs_vco_div
    import ccs_pkg::*;
#(
    parameter int DIV_LOG2 = CCS_DIV_LOG2
) (
    input  wire logic     clock,
    input  wire logic     rst_n,
    output var ccs_vco_t  vco
);

    localparam int CW = DIV_LOG2 + 2;

    // refuse divider sizes the counter cannot serve
    if (DIV_LOG2 < 0 || DIV_LOG2 > CCS_DIV_MAX) begin : g_bad_div
        $error("ccs_vco_div: DIV_LOG2 out of range");
    end

    logic [CW-1:0] cnt_q;      // free-running phase counter
    logic [CW-1:0] cnt_d;      // next count
    logic          rise_q;     // registered half-clock rising tick
    wire           rise_w;     // count about to enter half-high region

    // both clocks share one counter so they are low together at count zero
    assign cnt_d  = cnt_q + CW'(1);
    assign rise_w = (cnt_d[CW-1] == 1'b1) && (cnt_d[CW-2:0] == '0);

    // ---------------------------------------------------------------------------
    // counter
    // ---------------------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q  <= '0;
            rise_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            rise_q <= rise_w;
        end
    end

    // one driver for the whole carrier: nom, half, half_rise in field order
    assign vco = {cnt_q[CW-2], cnt_q[CW-1], rise_q};

endmodule
`default_nettype wire

// file: sim/ccs_clock_ctl_test.sv
`timescale 1ns/100ps
`default_nettype none
`define ccs_check(got, exp, msg) \
    begin \
        samples_checked++; \
        if ((got) !== (exp)) begin \
            err_count++; \
            $display("unexpected at %0t: %s", $time, msg); \
        end \
    end
// ---------------------------------------------------------------------------
// bench for the output clock control block
// ---------------------------------------------------------------------------
module ccs_clock_ctl_test
    import ccs_pkg::*;
;
    localparam int DIV   = 1;                // divider exponent under test
    localparam int P_NOM = 2 ** (DIV + 1);   // nominal output period
    localparam int P_HLF = 2 ** (DIV + 2);   // half-speed output period
    localparam int W_MAX = 2 ** (DIV + 3) + 8; // bound on any mode switch
    logic                  clock;            // 20 MHz system clock
    logic                  rst_n;            // async reset, active low
    wire logic [1:0]       sd_code;          // shutdown code pins
    wire logic             sel;              // half-speed request pin
    logic [2:0]            gclk;             // bank outputs
    logic                  act;              // half-speed source in use
    logic [2:0]            prev;             // outputs one edge ago
    int                    run [3];          // current level run length
    int                    err_count;        // mismatches
    int                    samples_checked;  // comparisons

    ccs_clock_ctl #(.DIV_LOG2(DIV)) u_ccs_clock_ctl (
        .clock(clock), .rst_n(rst_n), .output_group_disable(sd_code),
        .half_speed_select(sel), .group_clk_q(gclk), .half_speed_active_q(act));
    ccs_pm_model u_ccs_pm_model (
        .clock(clock), .output_group_disable(sd_code), .half_speed_select(sel));

    initial clock = 1'b0;
    always #25 clock = ~clock;

    // ---------------------------------------------------------------------------
    // pulse width watch: any runt on any bank shows up here
    // ---------------------------------------------------------------------------
    always @(posedge clock) begin
        #1;
        for (int b = 0; b < 3; b++) begin
            if (rst_n !== 1'b1) begin
                run[b] = 0;
            end else if (gclk[b] !== prev[b]) begin
                if (prev[b] === 1'b1) `ccs_check(run[b] == P_NOM / 2 || run[b] == P_HLF / 2, 1'b1, "high width")
                if (prev[b] === 1'b0) `ccs_check(run[b] >= P_NOM / 2, 1'b1, "low width")
                run[b] = 1;
            end else begin
                run[b]++;
            end
        end
        prev = gclk;
    end

    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // cycles until bank a rises, bounded
    task automatic wait_rise(output int cyc);
        logic p;
        cyc = 0;
        p = gclk[0];
        while (!(p === 1'b0 && gclk[0] === 1'b1)) begin
            p = gclk[0];
            @(posedge clock);
            #1;
            cyc++;
            if (cyc > W_MAX) begin
                err_count++;
                $display("unexpected at %0t: no rising edge", $time);
                give_verdict();
            end
        end
    endtask

    // each code from all-off back to all-on, checking hold-low and phase
    task automatic test_codes();
        logic [1:0] codes [4] = '{2'h3, 2'h2, 2'h1, 2'h0};
        logic [2:0] masks [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
        for (int i = 0; i < 4; i++) begin
            u_ccs_pm_model.set_code(codes[i]);
            repeat (W_MAX) @(posedge clock);
            for (int k = 0; k < 2 * P_NOM; k++) begin
                @(posedge clock);
                #2;
                for (int b = 0; b < 3; b++) begin
                    if (!masks[i][b]) `ccs_check(gclk[b], 1'b0, "bank not held low")
                    if (masks[i][b]) `ccs_check(gclk[b], gclk[0], "bank out of phase")
                end
            end
        end
    endtask

    // enter or leave half speed, then check switch point and period
    task automatic test_half(input logic v, input int per);
        int n;
        int c;
        n = 0;
        u_ccs_pm_model.set_half(v);
        while (act !== v && n <= W_MAX) begin
            @(posedge clock);
            #2;
            n++;
        end
        `ccs_check(act, v, "source not switched")
        `ccs_check(n > CCS_SYNC_STAGES, 1'b1, "switch before sync")
        `ccs_check(gclk, 3'h0, "switch while high")
        wait_rise(c);
        wait_rise(c);
        `ccs_check(c, per, "output period")
    endtask

    // mid-run reset: outputs low and nominal source while held
    task automatic test_reset();
        @(posedge clock);
        rst_n <= 1'b0;
        @(posedge clock);
        #2;
        `ccs_check(gclk, 3'h0, "outputs not low in reset")
        `ccs_check(act, 1'b0, "source not nominal in reset")
        @(posedge clock);
        rst_n <= 1'b1;
        repeat (W_MAX) @(posedge clock);
    endtask

    initial begin
        err_count = 0;
        samples_checked = 0;
        prev = 3'h0;
        rst_n = 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        test_codes();
        test_half(1'b1, P_HLF);
        test_half(1'b0, P_NOM);
        test_reset();
        give_verdict();
    end
endmodule
`default_nettype wire

// file: sim/ccs_pm_model.sv
`timescale 1ns/100ps
`default_nettype none
// ---------------------------------------------------------------------------
// power management controller on the control pins
// ---------------------------------------------------------------------------
module ccs_pm_model
    import ccs_pkg::*;
(
    input  wire logic                  clock,
    output logic [CCS_CODE_W-1:0]      output_group_disable,
    output logic                       half_speed_select
);
    // normal mode first
    // select starts low, internal feedback assumed so halving keeps lock
    initial begin
        output_group_disable = CCS_SD_NONE;
        half_speed_select    = 1'b0;
    end

    // no external feedback
    // crystal choice is moot here: only internal feedback is modelled
    task automatic set_code(input logic [CCS_CODE_W-1:0] code);
        @(posedge clock);
        output_group_disable <= code;
    endtask

    // pins change just after an edge, like a real synchronous controller
    task automatic set_half(input logic sel);
        @(posedge clock);
        half_speed_select <= sel;
    endtask
endmodule
`default_nettype wire
